// ### hdl/sasc_map.svh
// Purpose: register map, field positions and reset values of the scan controller
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by the controller and the testbench
`ifndef SASC_MAP_SVH
`define SASC_MAP_SVH
`define SASC_ADDR_W       16
`define SASC_OFF_CTRL     16'hF800
`define SASC_OFF_IMODE    16'hF804
`define SASC_OFF_TRIG     16'hF808
`define SASC_OFF_CHEN     16'hF80C
`define SASC_OFF_INTV     16'hF810
`define SASC_OFF_ISTAT    16'hF814
`define SASC_OFF_IMASK    16'hF818
`define SASC_NUM_CH       14
`define SASC_CTRL_START   0
`define SASC_CTRL_REPEAT  1
`define SASC_CTRL_STOP    2
`define SASC_IMODE_PERCH  0
`define SASC_IMODE_NOLIM  1
`define SASC_IST_CONV     0
`define SASC_IST_SCAN     1
`define SASC_CHEN_RST     14'h0000
`define SASC_IMODE_RST    2'h0
`define SASC_TRIG_RST     4'h0
`define SASC_INTV_RST     16'h0000
`define SASC_HS_DIV       4
`endif

// ### hdl/sasc_pkg.sv
// Purpose: types shared by the scan controller and its environment
// Assumes: 14 analog channels, channel number fits 4 bits
// Notes:   constants live in sasc_map.svh
package sasc_pkg;
  // Scan sequencer states
  typedef enum logic [1:0] {
    SASC_IDLE = 2'b00,
    SASC_CONV = 2'b01,
    SASC_GAP  = 2'b10
  } sasc_state_t;
  // Request toward the analog core
  typedef struct packed {
    logic       valid;
    logic [3:0] channel;
  } sasc_conv_req_t;
  // Answer from the analog core
  typedef struct packed {
    logic done;
    logic limit_hit;
  } sasc_conv_rsp_t;
endpackage

// ### hdl/sasc_ctrl.sv
// Purpose: channel scan sequencer and interrupt control of a SAR converter
// Assumes: analog core on pclk; it answers a held request with a done pulse
// Notes:   APB slave with no wait state; unmapped access gives pslverr
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "sasc_map.svh"

module sasc_ctrl #(
  parameter int HS_DIV = `SASC_HS_DIV
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [`SASC_ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output sasc_pkg::sasc_conv_req_t          conv_req,
  input  wire sasc_pkg::sasc_conv_rsp_t     conv_rsp,
  output logic      [3:0]                   trigger_source,
  output logic                              conv_irq_pulse,
  output logic                              irq
);
  import sasc_pkg::*;

  localparam int NCH = `SASC_NUM_CH;

  // Registers
  logic [NCH-1:0]   chen_reg;
  logic [1:0]       imode_reg;
  logic [3:0]       trig_reg;
  logic [15:0]      intv_reg;
  logic             repeat_reg;
  logic [1:0]       istat_reg;
  logic [1:0]       imask_reg;
  logic             running_reg;
  sasc_state_t      state_reg;
  sasc_state_t      state_next;
  logic [3:0]       ch_reg;
  logic [3:0]       ch_next;
  logic [15:0]      gap_reg;
  logic [15:0]      gap_next;
  logic [7:0]       div_reg;
  logic             hs_tick;
  logic [1:0]       istat_next;

  // Lowest enabled channel at or above a start index, found flag on top
  function automatic logic [4:0] find_from(input logic [NCH-1:0] en,
                                           input logic [4:0] from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i] && (i >= int'(from))) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Bus decode
  wire acc     = psel & penable & pready;
  wire wr      = acc & pwrite;
  wire a_ctrl  = (paddr == `SASC_OFF_CTRL);
  wire a_imode = (paddr == `SASC_OFF_IMODE);
  wire a_trig  = (paddr == `SASC_OFF_TRIG);
  wire a_chen  = (paddr == `SASC_OFF_CHEN);
  wire a_intv  = (paddr == `SASC_OFF_INTV);
  wire a_istat = (paddr == `SASC_OFF_ISTAT);
  wire a_imask = (paddr == `SASC_OFF_IMASK);
  wire a_hit   = a_ctrl | a_imode | a_trig | a_chen | a_intv | a_istat | a_imask;

  // Read data selection, reserved bits zero
  wire [31:0] rd_mux =
    a_ctrl  ? {30'h0, repeat_reg, running_reg} :
    a_imode ? {30'h0, imode_reg} :
    a_trig  ? {28'h0, trig_reg} :
    a_chen  ? {18'h0, chen_reg} :
    a_intv  ? {16'h0, intv_reg} :
    a_istat ? {30'h0, istat_reg} :
    a_imask ? {30'h0, imask_reg} : 32'h0000_0000;

  // Software commands
  wire start_cmd = wr & a_ctrl & pwdata[`SASC_CTRL_START];
  wire stop_cmd  = wr & a_ctrl & pwdata[`SASC_CTRL_STOP];

  // Channel search results
  wire [4:0] first_hit = find_from(chen_reg, 5'h00);
  wire [4:0] next_hit  = find_from(chen_reg, 5'(ch_reg) + 5'h01);
  wire       done      = (state_reg == SASC_CONV) & conv_rsp.done;
  wire       last_ch   = ~next_hit[4];

  wire point_evt = imode_reg[`SASC_IMODE_PERCH] ? done : (done & last_ch);
  wire qual_evt  = point_evt &
                   (imode_reg[`SASC_IMODE_NOLIM] | conv_rsp.limit_hit);
  wire scan_evt  = done & last_ch;

  // Sticky status, set wins over clear
  wire [1:0] clr_bits = (wr & a_istat) ? pwdata[1:0] : 2'h0;
  assign istat_next = (istat_reg & ~clr_bits) | {scan_evt, qual_evt};

  // High-speed clock enable from divider
  assign hs_tick = (div_reg == 8'(HS_DIV - 1));

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    ch_next    = ch_reg;
    gap_next   = gap_reg;
    unique case (state_reg)
      SASC_IDLE: begin
        if (start_cmd && first_hit[4]) begin
          state_next = SASC_CONV;
          ch_next    = first_hit[3:0];
        end
      end
      SASC_CONV: begin
        if (stop_cmd) begin
          state_next = SASC_IDLE;
        end else if (done && !last_ch) begin
          ch_next = next_hit[3:0];
        end else if (done && repeat_reg) begin
          state_next = SASC_GAP;
          gap_next   = intv_reg;
        end else if (done) begin
          state_next = SASC_IDLE;
        end
      end
      SASC_GAP: begin
        if (stop_cmd || !first_hit[4]) begin
          state_next = SASC_IDLE;
        end else if (gap_reg == 16'h0000) begin
          state_next = SASC_CONV;
          ch_next    = first_hit[3:0];
        end else if (hs_tick) begin
          gap_next = gap_reg - 16'h0001;
        end
      end
      default: begin
        state_next = SASC_IDLE;
      end
    endcase
  end

  // APB answer, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~a_hit;
    end
  end

  // Read data, zero outside the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chen_reg <= `SASC_CHEN_RST;
    end else if (wr && a_chen) begin
      chen_reg <= pwdata[NCH-1:0];
    end
  end

  // Interrupt timing mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imode_reg <= `SASC_IMODE_RST;
    end else if (wr && a_imode) begin
      imode_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_reg <= `SASC_TRIG_RST;
    end else if (wr && a_trig) begin
      trig_reg <= pwdata[3:0];
    end
  end

  // Scan interval setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intv_reg <= `SASC_INTV_RST;
    end else if (wr && a_intv) begin
      intv_reg <= pwdata[15:0];
    end
  end

  // Repeat flag, written with every control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      repeat_reg <= 1'b0;
    end else if (wr && a_ctrl) begin
      repeat_reg <= pwdata[`SASC_CTRL_REPEAT];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_reg <= 2'h0;
    end else if (wr && a_imask) begin
      imask_reg <= pwdata[1:0];
    end
  end

  // Sequencer state, channel and gap counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SASC_IDLE;
      ch_reg    <= 4'h0;
      gap_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      ch_reg    <= ch_next;
      gap_reg   <= gap_next;
    end
  end

  // High-speed clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= hs_tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Running flag, read back by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_reg <= 1'b0;
    end else begin
      running_reg <= (state_next != SASC_IDLE);
    end
  end

  // Request toward the analog core, low for a cycle after done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_req <= '0;
    end else begin
      conv_req.valid   <= (state_next == SASC_CONV) & ~done;
      conv_req.channel <= ch_next;
    end
  end

  // Trigger select copy to the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_source <= 4'h0;
    end else begin
      trigger_source <= trig_reg;
    end
  end

  // Sticky status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= 2'h0;
    end else begin
      istat_reg <= istat_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq_pulse <= 1'b0;
    end else begin
      conv_irq_pulse <= qual_evt;
    end
  end

  // Level interrupt from masked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_next & imask_reg);
    end
  end

endmodule

// ### tb/sasc_ctrl_properties.sv
// Purpose: port-level properties of the scan controller
// Assumes: one pclk domain, presetn low resets
// Notes:   bound to every sasc_ctrl instance
`timescale 1ns/1ps
module sasc_ctrl_properties (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire sasc_pkg::sasc_conv_req_t conv_req,
  input wire sasc_pkg::sasc_conv_rsp_t conv_rsp,
  input wire logic [3:0]               trigger_source,
  input wire logic                     conv_irq_pulse
);
  import sasc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_done;
    pwrite && pready;
  endsequence
  // Bus answer timing
  property p_rdy; s_setup |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  // Request pulse and its cause
  property p_pulse; conv_irq_pulse |=> !conv_irq_pulse; endproperty
  property p_cause; conv_irq_pulse |-> $past(conv_rsp.done); endproperty
  // Channel under conversion
  property p_range; conv_req.valid |-> conv_req.channel <= 4'hD; endproperty
  property p_hold;
    conv_req.valid && $past(conv_req.valid) |-> $stable(conv_req.channel);
  endproperty
  // Trigger select moves only after a write
  property p_trig;
    $changed(trigger_source) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_err: assert property (p_err) else $error("error without ready");
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  a_pulse: assert property (p_pulse) else $error("request pulse too long");
  a_cause: assert property (p_cause) else $error("request without done");
  a_range: assert property (p_range) else $error("channel out of range");
  a_hold: assert property (p_hold) else $error("channel moved mid conversion");
  a_trig: assert property (p_trig) else $error("trigger moved without write");
  c_wr: cover property (s_wr_done);
endmodule
bind sasc_ctrl sasc_ctrl_properties sasc_ctrl_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_req(conv_req), .conv_rsp(conv_rsp), .trigger_source(trigger_source),
  .conv_irq_pulse(conv_irq_pulse)
);

// ### tb/sasc_ctrl_tb.sv
// Purpose: directed checks of the scan controller over APB
// Assumes: analog core answered by the bench, HS_DIV set to 1
// Notes:   prints mismatches and the verdict only
`timescale 1ns/1ps
`include "sasc_map.svh"
module sasc_ctrl_tb;
  import sasc_pkg::*;
  logic           pclk = 1'b0;
  logic           presetn = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [15:0]    paddr = 16'h0;
  logic [31:0]    pwdata = 32'h0;
  logic [31:0]    prdata, rd;
  logic           pready, pslverr, err, conv_irq_pulse, irq;
  logic [3:0]     trigger_source;
  logic [3:0]     chs[2] = '{4'h2, 4'h5};
  sasc_conv_req_t conv_req;
  sasc_conv_rsp_t conv_rsp = '0;
  int             fail_count = 0, n_compared = 0, npulse = 0;
  always #2.5 pclk = ~pclk;
  // Count request pulses
  always @(posedge pclk) if (conv_irq_pulse === 1'b1) npulse <= npulse + 1;
  sasc_ctrl #(.HS_DIV(1)) sasc_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_req(conv_req),
    .conv_rsp(conv_rsp), .trigger_source(trigger_source),
    .conv_irq_pulse(conv_irq_pulse), .irq(irq)
  );
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic t_empty();
    bus(1'b1, `SASC_OFF_CTRL, 32'h1);
    rdchk(`SASC_OFF_CTRL, 32'h0, "idle_run");
    chk("idle_req", 32'h0, conv_req.valid);
  endtask
  task automatic t_regs();
    rdchk(`SASC_OFF_CHEN, 32'h0, "chen_rst");
    rdchk(`SASC_OFF_IMODE, 32'h0, "imode_rst");
    rdchk(`SASC_OFF_TRIG, 32'h0, "trig_rst");
    bus(1'b1, `SASC_OFF_TRIG, 32'hFFFFFFFF);
    rdchk(`SASC_OFF_TRIG, 32'hF, "trig_rw");
    chk("trig_out", 32'hF, trigger_source);
    bus(1'b1, `SASC_OFF_CHEN, 32'hFFFFFFFF);
    rdchk(`SASC_OFF_CHEN, 32'h3FFF, "chen_rw");
    rdchk(16'hF81C, 32'h0, "unmapped");
    chk("slverr", 32'h1, err);
  endtask
  // Scan of channels 2 and 5, limit match on channel 2 only
  task automatic t_scan(input logic [1:0] m, input int exp);
    int k;
    bus(1'b1, `SASC_OFF_IMODE, {30'h0, m});
    bus(1'b1, `SASC_OFF_CHEN, 32'h24);
    bus(1'b1, `SASC_OFF_IMASK, 32'h2);
    npulse = 0;
    bus(1'b1, `SASC_OFF_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      k = 0;
      do @(negedge pclk); while (conv_req.valid !== 1'b1 && ++k < 50);
      chk("channel", chs[i], conv_req.channel);
      @(posedge pclk);
      conv_rsp <= '{1'b1, chs[i] == 4'h2};
      @(posedge pclk);
      conv_rsp <= '0;
    end
    repeat (4) @(posedge pclk);
    chk("pulses", exp, npulse);
    chk("irq_set", 32'h1, irq);
    bus(1'b1, `SASC_OFF_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_mask", 32'h0, irq);
    bus(1'b1, `SASC_OFF_ISTAT, 32'h3);
    rdchk(`SASC_OFF_ISTAT, 32'h0, "stat_clr");
  endtask
  // Repeat scan: gap of interval plus one cycle, restart at lowest, then stop
  task automatic t_gap();
    int k;
    bus(1'b1, `SASC_OFF_INTV, 32'h3);
    bus(1'b1, `SASC_OFF_CTRL, 32'h3);
    for (int i = 0; i < 3; i++) begin
      k = 0;
      do @(negedge pclk); while (conv_req.valid !== 1'b1 && ++k < 50);
      chk("rep_channel", chs[i % 2], conv_req.channel);
      if (i == 2) chk("gap_len", 32'h4, k);
      if (i < 2) begin
        @(posedge pclk);
        conv_rsp <= '{1'b1, 1'b0};
        @(posedge pclk);
        conv_rsp <= '0;
      end
    end
    bus(1'b1, `SASC_OFF_CTRL, 32'h4);
    rdchk(`SASC_OFF_CTRL, 32'h0, "stopped");
    chk("stop_req", 32'h0, conv_req.valid);
  endtask
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_empty();
    t_regs();
    t_scan(2'h0, 0);
    t_scan(2'h1, 1);
    t_scan(2'h2, 1);
    t_scan(2'h3, 2);
    t_gap();
    complete_run();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule
